// [hw/stfms_consts.svh]
// Purpose: Named numbers of the stepper fault and mode supervisor
// Assumes: 20 MHz hclk
// Notes: Times in ns; cycle counts derived, least times rounded up
`ifndef STFMS_CONSTS_SVH
`define STFMS_CONSTS_SVH

`define STFMS_CLK_NS 50
`define STFMS_CYC_UP(ns) (((ns) + `STFMS_CLK_NS - 1) / `STFMS_CLK_NS)

`define STFMS_T_SLEEP_NS 1000
`define STFMS_T_WAKE_NS 1000
`define STFMS_T_OCP_NS 2000
`define STFMS_T_RETRY_NS 1000000
`define STFMS_SLEEP_CYC `STFMS_CYC_UP(`STFMS_T_SLEEP_NS)
`define STFMS_WAKE_CYC `STFMS_CYC_UP(`STFMS_T_WAKE_NS)
`define STFMS_OCP_CYC `STFMS_CYC_UP(`STFMS_T_OCP_NS)
`define STFMS_RETRY_CYC `STFMS_CYC_UP(`STFMS_T_RETRY_NS)

`define STFMS_T_OFF10_NS 10000
`define STFMS_T_OFF20_NS 20000
`define STFMS_T_OFF30_NS 30000
`define STFMS_T_BLK09_NS 900
`define STFMS_T_BLK12_NS 1200
`define STFMS_T_BLK15_NS 1500
`define STFMS_T_BLK18_NS 1800

`define STFMS_ADDR_CTRL 8'h00
`define STFMS_ADDR_STATE 8'h04
`define STFMS_ADDR_IRQ_STAT 8'h08
`define STFMS_ADDR_IRQ_MASK 8'h0c
`define STFMS_CTRL_RST 4'h0
`define STFMS_MASK_RST 5'h00
// Sleep request idles high; a zero here would fake a sleep fall after reset
`define STFMS_SYNC_RST 13'h0080

`define STFMS_EV_OT 0
`define STFMS_EV_UV 1
`define STFMS_EV_OCA 2
`define STFMS_EV_OCB 3
`define STFMS_EV_SLP 4

`define STFMS_FULL_INC 7'h20
`define STFMS_MS_MAX 3'h5

`endif

// [hw/stfms_pkg.sv]
// Purpose: Types of the stepper fault and mode supervisor
// Assumes: One-hot state codes
// Notes: Numbers live in stfms_consts.svh
package stfms_pkg;

	typedef enum logic [3:0] {
		MD_ACTIVE = 4'b0001,
		MD_SLPWAIT = 4'b0010,
		MD_SLEEP = 4'b0100,
		MD_WAKE = 4'b1000
	} stfms_mode_e;

	typedef enum logic [3:0] {
		CH_OFF = 4'b0001,
		CH_BLANK = 4'b0010,
		CH_DRIVE = 4'b0100,
		CH_DECAY = 4'b1000
	} stfms_chop_e;

	typedef logic [15:0] stfms_cnt_t;

endpackage

// [hw/stfms_ocp.sv]
// Purpose: Overcurrent deglitch, shutdown and retry for one bridge
// Assumes: limit already synchronised to hclk
// Notes: clr is the undervoltage reset
`timescale 1ns/1ns
`include "stfms_consts.svh"
module stfms_ocp import stfms_pkg::*; #(
	parameter stfms_cnt_t RETRY_CYC = 16'(`STFMS_RETRY_CYC)
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clr,
	// Sense and result
	input wire logic limit,
	output logic trip_q
);
	stfms_cnt_t cnt_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trip_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else if (clr) begin
			trip_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else if (!trip_q) begin
			// Trip only once the limit outlasts the deglitch time
			if (!limit) begin
				cnt_q <= 16'h0000;
			end else if (cnt_q == 16'(`STFMS_OCP_CYC)) begin
				trip_q <= 1'b1;
				cnt_q <= 16'h0000;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end else if (cnt_q == RETRY_CYC - 16'h0001) begin
			trip_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	chk_ocp_deglitch: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(trip_q) |-> $past(limit) && $past(cnt_q) == 16'(`STFMS_OCP_CYC))
		else $error("overcurrent trip without full deglitch");

	chk_ocp_retry_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(trip_q) |-> $past(clr) || $past(cnt_q) == RETRY_CYC - 16'h0001)
		else $error("overcurrent released before retry time");
endmodule

// [hw/stfms_chop.sv]
// Purpose: Fixed off-time chopper with blanking for one bridge
// Assumes: cmp synchronised; blank and off counts at least one
// Notes: Comparator is blind during blanking
`timescale 1ns/1ns
`include "stfms_consts.svh"
module stfms_chop import stfms_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic run,
	input wire logic cmp,
	input wire logic [5:0] blank_cyc,
	input wire logic [9:0] off_cyc,
	// Phase
	output logic drive_q,
	output logic decay_q
);
	stfms_chop_e st_q;
	logic [9:0] cnt_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= CH_OFF;
			cnt_q <= 10'h000;
			drive_q <= 1'b0;
			decay_q <= 1'b0;
		end else if (!run) begin
			st_q <= CH_OFF;
			drive_q <= 1'b0;
			decay_q <= 1'b0;
		end else begin
			case (st_q)
				CH_OFF, CH_DECAY: begin
					if (st_q == CH_OFF || cnt_q == 10'h001) begin
						st_q <= CH_BLANK;
						cnt_q <= {4'h0, blank_cyc};
						drive_q <= 1'b1;
						decay_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 10'h001;
					end
				end
				CH_BLANK: begin
					if (cnt_q == 10'h001) begin
						st_q <= CH_DRIVE;
					end
					cnt_q <= cnt_q - 10'h001;
				end
				CH_DRIVE: begin
					if (cmp) begin
						st_q <= CH_DECAY;
						cnt_q <= off_cyc;
						drive_q <= 1'b0;
						decay_q <= 1'b1;
					end
				end
				default: begin
					st_q <= CH_OFF;
				end
			endcase
		end
	end

	chk_blank_min_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(decay_q) |-> $past(st_q) == CH_DRIVE)
		else $error("decay entered inside blanking");

	chk_off_time_len: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(decay_q) && off_cyc == 10'(`STFMS_CYC_UP(`STFMS_T_OFF10_NS)) && run
		|-> decay_q [*8])
		else $error("decay ended before off time");
endmodule

// [hw/stfms_top.sv]
// Purpose: Fault, mode and chopping supervisor of a dual bridge stepper
// Assumes: Pins and sensors asynchronous; AHB-Lite register access
// Notes: Undervoltage clears all motor-side state, not the registers
//
// How it works
// - Overtemperature cuts both bridges, fault low
// - Resume on cool; release fault after resume
// - Undervoltage resets all motor-side logic and indexer
// - Restart on recovery; fault low meanwhile
// - Overcurrent holds bridge off for retry time
// - Fault indication clears itself on recovery
// - Sleep after delay; regulator off, bridges hi-z
// - Wake on sleep pin high after wake delay
// - Disabled outputs still let indexer advance
// - Fixed off-time decay after chopping threshold
// - Comparator ignored during blanking drive time
// - Full step down to 1/32 step
// - Overcurrent needs limit beyond deglitch time
// - Overcurrent handled per bridge independently
`timescale 1ns/1ns
`include "stfms_consts.svh"
module stfms_top import stfms_pkg::*; #(
	parameter stfms_cnt_t RETRY_CYC = 16'(`STFMS_RETRY_CYC)
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Controller pins
	input wire logic step_pin,
	input wire logic dir_pin,
	input wire logic [2:0] microstep_select,
	input wire logic sleep_request_low,
	input wire logic output_disable_pin,
	// Sensors
	input wire logic overtemp_shutdown,
	input wire logic undervoltage_lockout,
	input wire logic [1:0] overcurrent_trip,
	input wire logic [1:0] chopping_threshold,
	// Bridge and regulator
	output logic [1:0] bridge_drive,
	output logic [1:0] bridge_decay,
	output logic bridge_hiz,
	output logic internal_regulator,
	output logic [6:0] step_position,
	// Open-drain fault pin
	input wire logic fault_indicator_low_i,
	output logic fault_indicator_low_o,
	output logic fault_indicator_low_oe,
	// Interrupt
	output logic irq
);
	function automatic logic [9:0] off_cycles(input logic [1:0] sel);
		case (sel)
			2'h1: off_cycles = 10'(`STFMS_CYC_UP(`STFMS_T_OFF20_NS));
			2'h2: off_cycles = 10'(`STFMS_CYC_UP(`STFMS_T_OFF30_NS));
			default: off_cycles = 10'(`STFMS_CYC_UP(`STFMS_T_OFF10_NS));
		endcase
	endfunction

	function automatic logic [5:0] blank_cycles(input logic [1:0] sel);
		case (sel)
			2'h1: blank_cycles = 6'(`STFMS_CYC_UP(`STFMS_T_BLK12_NS));
			2'h2: blank_cycles = 6'(`STFMS_CYC_UP(`STFMS_T_BLK15_NS));
			2'h3: blank_cycles = 6'(`STFMS_CYC_UP(`STFMS_T_BLK18_NS));
			default: blank_cycles = 6'(`STFMS_CYC_UP(`STFMS_T_BLK09_NS));
		endcase
	endfunction

	function automatic logic [6:0] step_inc(input logic [2:0] sel);
		step_inc = (sel > `STFMS_MS_MAX) ? 7'h01 : (`STFMS_FULL_INC >> sel);
	endfunction

	// Two-stage synchronisers for every pin and sensor
	logic [12:0] sync1_q;
	logic [12:0] sync2_q;
	logic step_s, dir_s, slp_s, dis_s, ot_s, uv_s;
	logic [2:0] ms_s;
	logic [1:0] oc_s, cmp_s;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= `STFMS_SYNC_RST;
			sync2_q <= `STFMS_SYNC_RST;
		end else begin
			sync1_q <= {step_pin, dir_pin, microstep_select, sleep_request_low,
				output_disable_pin, overtemp_shutdown, undervoltage_lockout,
				overcurrent_trip, chopping_threshold};
			sync2_q <= sync1_q;
		end
	end

	assign {step_s, dir_s, ms_s, slp_s, dis_s, ot_s, uv_s, oc_s, cmp_s} = sync2_q;

	// Register file
	logic [3:0] ctrl_q;
	logic [4:0] ev_q;
	logic [4:0] mask_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic rd_take;
	logic [31:0] rd_val;
	logic [4:0] ev_set;
	logic [4:0] ev_clr;

	// Mode, indexer and fault state
	stfms_mode_e mode_q;
	stfms_cnt_t mcnt_q;
	logic [6:0] idx_q;
	logic step_prev_q;
	logic slp_prev_q;
	logic [1:0] trip;
	logic fault_now;
	logic fault_prev_q;
	logic [3:0] cond_prev_q;
	logic [1:0] run;

	assign fault_now = ot_s | uv_s | (|trip);

	// Sleep and wake sequencing, restart after undervoltage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= MD_ACTIVE;
			mcnt_q <= 16'h0000;
			slp_prev_q <= 1'b1;
		end else if (uv_s) begin
			mode_q <= MD_ACTIVE;
			mcnt_q <= 16'h0000;
			slp_prev_q <= 1'b1;
		end else begin
			slp_prev_q <= slp_s;
			mcnt_q <= mcnt_q + 16'h0001;
			case (mode_q)
				MD_ACTIVE: begin
					if (slp_prev_q && !slp_s) begin
						mode_q <= MD_SLPWAIT;
						mcnt_q <= 16'h0000;
					end
				end
				MD_SLPWAIT: begin
					if (slp_s) begin
						mode_q <= MD_ACTIVE;
					end else if (mcnt_q == 16'(`STFMS_SLEEP_CYC) - 16'h0001) begin
						mode_q <= MD_SLEEP;
					end
				end
				MD_SLEEP: begin
					mcnt_q <= 16'h0000;
					if (slp_s) begin
						mode_q <= MD_WAKE;
					end
				end
				MD_WAKE: begin
					if (!slp_s) begin
						mode_q <= MD_SLEEP;
					end else if (mcnt_q == 16'(`STFMS_WAKE_CYC) - 16'h0001) begin
						mode_q <= MD_ACTIVE;
					end
				end
				default: begin
					mode_q <= MD_ACTIVE;
				end
			endcase
		end
	end

	// Indexer keeps counting while outputs are disabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_q <= 7'h00;
			step_prev_q <= 1'b0;
		end else if (uv_s) begin
			idx_q <= 7'h00;
			step_prev_q <= 1'b0;
		end else begin
			step_prev_q <= step_s;
			if (step_s && !step_prev_q && mode_q == MD_ACTIVE) begin
				// Wraps over one electrical cycle of 128 microsteps
				if (dir_s) begin
					idx_q <= idx_q + step_inc(ms_s);
				end else begin
					idx_q <= idx_q - step_inc(ms_s);
				end
			end
		end
	end

	// Per-bridge overcurrent; one bridge tripping leaves the other running
	stfms_ocp #(.RETRY_CYC(RETRY_CYC)) u_ocp_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(uv_s),
		.limit(oc_s[0]),
		.trip_q(trip[0])
	);

	stfms_ocp #(.RETRY_CYC(RETRY_CYC)) u_ocp_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(uv_s),
		.limit(oc_s[1]),
		.trip_q(trip[1])
	);

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			run[i] = mode_q == MD_ACTIVE && !dis_s && !ot_s && !uv_s && !trip[i];
		end
	end

	stfms_chop u_chop_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(run[0]),
		.cmp(cmp_s[0]),
		.blank_cyc(blank_cycles(ctrl_q[3:2])),
		.off_cyc(off_cycles(ctrl_q[1:0])),
		.drive_q(bridge_drive[0]),
		.decay_q(bridge_decay[0])
	);

	stfms_chop u_chop_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(run[1]),
		.cmp(cmp_s[1]),
		.blank_cyc(blank_cycles(ctrl_q[3:2])),
		.off_cyc(off_cycles(ctrl_q[1:0])),
		.drive_q(bridge_drive[1]),
		.decay_q(bridge_decay[1])
	);

	// Bridge state, regulator and position shown on the outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bridge_hiz <= 1'b1;
			internal_regulator <= 1'b0;
			step_position <= 7'h00;
		end else begin
			bridge_hiz <= mode_q == MD_SLEEP || mode_q == MD_WAKE || uv_s;
			internal_regulator <= mode_q != MD_SLEEP && !uv_s;
			if (uv_s) begin
				step_position <= 7'h00;
			end else if (mode_q == MD_ACTIVE && !dis_s) begin
				step_position <= idx_q;
			end
		end
	end

	// Fault pin held one cycle past recovery so release follows resumption
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_prev_q <= 1'b0;
			fault_indicator_low_oe <= 1'b0;
			fault_indicator_low_o <= 1'b0;
		end else begin
			fault_prev_q <= fault_now;
			fault_indicator_low_oe <= fault_now | fault_prev_q;
			fault_indicator_low_o <= 1'b0;
		end
	end

	// Events: rising edges of undervoltage, each trip and entry into sleep; overtemperature rising with no other fault active
	assign ev_set = {mode_q == MD_SLEEP && !cond_prev_q[3], trip & ~cond_prev_q[2:1],
		uv_s && !cond_prev_q[0], 1'b0} | {4'h0, ot_s && !fault_prev_q && !uv_s && !(|trip)};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cond_prev_q <= 4'h0;
		end else begin
			cond_prev_q <= {mode_q == MD_SLEEP, trip, uv_s};
		end
	end

	// AHB-Lite: zero wait state, reads registered in the address phase
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	assign ev_clr = (wr_pend_q && wr_addr_q == `STFMS_ADDR_IRQ_STAT) ? hwdata[4:0] : 5'h00;

	always_comb begin
		case (haddr[7:0])
			`STFMS_ADDR_CTRL: rd_val = {28'h0000000, ctrl_q};
			`STFMS_ADDR_STATE: rd_val = {15'h0000, idx_q, trip, uv_s, ot_s,
				fault_now, dis_s, mode_q};
			`STFMS_ADDR_IRQ_STAT: rd_val = {27'h0000000, ev_q};
			`STFMS_ADDR_IRQ_MASK: rd_val = {27'h0000000, mask_q};
			default: rd_val = 32'h00000000;
		endcase
		if (haddr[31:8] != 24'h000000) begin
			rd_val = 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready) begin
				wr_pend_q <= hsel && htrans[1] && hwrite && haddr[31:8] == 24'h000000;
				wr_addr_q <= haddr[7:0];
			end
			if (rd_take) begin
				hrdata <= rd_val;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `STFMS_CTRL_RST;
			mask_q <= `STFMS_MASK_RST;
		end else if (wr_pend_q) begin
			if (wr_addr_q == `STFMS_ADDR_CTRL) begin
				ctrl_q <= hwdata[3:0];
			end
			if (wr_addr_q == `STFMS_ADDR_IRQ_MASK) begin
				mask_q <= hwdata[4:0];
			end
		end
	end

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_q <= 5'h00;
			irq <= 1'b0;
		end else begin
			ev_q <= (ev_q & ~ev_clr) | ev_set;
			irq <= |(((ev_q & ~ev_clr) | ev_set) & mask_q);
		end
	end

	chk_ot_cuts_bridge: assert property (@(posedge hclk) disable iff (!hresetn)
		ot_s |=> !bridge_drive[0] && !bridge_drive[1] ##1 fault_indicator_low_oe)
		else $error("bridge still driven under overtemperature");

	chk_fault_after_run: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(fault_indicator_low_oe) |-> $past(fault_prev_q, 2) && !$past(fault_prev_q)
		&& !$past(fault_now))
		else $error("fault released before operation resumed");

	chk_uv_resets_idx: assert property (@(posedge hclk) disable iff (!hresetn)
		uv_s |=> idx_q == 7'h00 && mode_q == MD_ACTIVE && !internal_regulator)
		else $error("undervoltage did not reset internal state");

	chk_uv_fault_low: assert property (@(posedge hclk) disable iff (!hresetn)
		uv_s ##1 uv_s |-> fault_indicator_low_oe)
		else $error("fault pin released during undervoltage");

	chk_fault_self_clr: assert property (@(posedge hclk) disable iff (!hresetn)
		!fault_now [*2] |=> !fault_indicator_low_oe)
		else $error("fault indication did not clear itself");

	chk_sleep_delay: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(mode_q == MD_SLEEP) && $past(mode_q) == MD_SLPWAIT
		|-> $past(mcnt_q) == 16'(`STFMS_SLEEP_CYC) - 16'h0001)
		else $error("sleep entered without sleep delay");

	chk_sleep_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
		mode_q == MD_SLEEP |=> bridge_hiz && !internal_regulator)
		else $error("sleep left bridge or regulator on");

	chk_wake_delay: assert property (@(posedge hclk) disable iff (!hresetn)
		mode_q == MD_WAKE |=> !bridge_drive[0] && !bridge_drive[1] && bridge_hiz)
		else $error("outputs changed during wake delay");

	chk_disable_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		dis_s && !uv_s ##1 dis_s && !uv_s |-> $stable(step_position) && !bridge_drive[0])
		else $error("outputs followed indexer while disabled");

	chk_ocp_indep: assert property (@(posedge hclk) disable iff (!hresetn)
		trip[0] && !trip[1] && !ot_s && !uv_s && !dis_s && mode_q == MD_ACTIVE
		|-> run[1] && !run[0])
		else $error("one bridge trip stopped the other bridge");

	chk_fault_or: assert property (@(posedge hclk) disable iff (!hresetn)
		fault_now |=> fault_indicator_low_oe)
		else $error("fault pin not low with a fault active");
endmodule

// [verification/stfms_ctrl_model.sv]
// Purpose: Motor controller model driving step, direction, sleep and disable pins
// Assumes: Pins change only just after a rising hclk edge
// Notes: Step pulses are 3 cycles high, 3 low, well above the 2-flop sync
`timescale 1ns/1ns
`include "stfms_consts.svh"
module stfms_ctrl_model (
	// Clock
	input wire logic hclk,
	// Controller pins
	output logic step_pin,
	output logic dir_pin,
	output logic [2:0] microstep_select,
	output logic sleep_request_low,
	output logic output_disable_pin
);
	initial begin
		step_pin = 1'b0;
		dir_pin = 1'b1;
		microstep_select = 3'h0;
		sleep_request_low = 1'b1;
		output_disable_pin = 1'b0;
	end

	task automatic steps(input int n, input logic d, input logic [2:0] ms);
		@(posedge hclk);
		dir_pin <= d;
		microstep_select <= ms;
		repeat (4) @(posedge hclk);
		repeat (n) begin
			step_pin <= 1'b1;
			repeat (3) @(posedge hclk);
			step_pin <= 1'b0;
			repeat (3) @(posedge hclk);
		end
		repeat (6) @(posedge hclk);
	endtask

	task automatic set_disable(input logic v);
		@(posedge hclk);
		output_disable_pin <= v;
	endtask

	task automatic go_sleep();
		@(posedge hclk);
		sleep_request_low <= 1'b0;
	endtask

	// No motion expected before the wake delay and sync have run out
	task automatic wake();
		@(posedge hclk);
		sleep_request_low <= 1'b1;
		repeat (`STFMS_WAKE_CYC + 6) @(posedge hclk);
	endtask
endmodule

// [verification/testbench.sv]
// Purpose: Self-checking bench of the stepper fault and mode supervisor
// Assumes: Zero wait-state slave; retry shortened to 50 cycles
// Notes: Chopper lengths allow one cycle of slack for phase alignment
`timescale 1ns/1ns
`include "stfms_consts.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module testbench import stfms_pkg::*;;
	typedef struct {logic [2:0] ms; logic d; logic [6:0] pos;} stfms_row_s;
	logic hclk, hresetn, hsel, hwrite, ot, uv, hreadyout, hresp, hiz, vreg, f_o, f_oe, irq;
	logic step_pin, dir_pin, sleep_request_low, output_disable_pin;
	logic [2:0] hsize, microstep_select;
	logic [1:0] htrans, oc, chop, drv, dec;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [6:0] pos;
	int n_errors, cmp_count, nd, nb;
	stfms_row_s rows[8] = '{'{3'h0, 1'b1, 7'h20}, '{3'h1, 1'b1, 7'h30}, '{3'h2, 1'b1, 7'h38},
		'{3'h3, 1'b1, 7'h3c}, '{3'h4, 1'b1, 7'h3e}, '{3'h5, 1'b1, 7'h3f},
		'{3'h7, 1'b1, 7'h40}, '{3'h0, 1'b0, 7'h20}};
	int off_c[4] = '{200, 400, 600, 200};
	int blk_c[4] = '{18, 24, 30, 36};

	stfms_top #(.RETRY_CYC(16'h0032)) i_stfms_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.step_pin(step_pin), .dir_pin(dir_pin), .microstep_select(microstep_select),
		.sleep_request_low(sleep_request_low), .output_disable_pin(output_disable_pin),
		.overtemp_shutdown(ot), .undervoltage_lockout(uv), .overcurrent_trip(oc),
		.chopping_threshold(chop), .bridge_drive(drv), .bridge_decay(dec), .bridge_hiz(hiz),
		.internal_regulator(vreg), .step_position(pos), .fault_indicator_low_i(!f_oe),
		.fault_indicator_low_o(f_o), .fault_indicator_low_oe(f_oe), .irq(irq));
	stfms_ctrl_model i_stfms_ctrl_model (.hclk(hclk), .step_pin(step_pin), .dir_pin(dir_pin),
		.microstep_select(microstep_select), .sleep_request_low(sleep_request_low),
		.output_disable_pin(output_disable_pin));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask

	// Waits on phase changes are bounded so a stuck chopper cannot hang the run
	task automatic run_len();
		int k;
		k = 0;
		while (dec[0] !== 1'b1 && k < 2000) begin cyc(1); k++; end
		nd = 0;
		while (dec[0] === 1'b1 && nd < 2000) begin cyc(1); nd++; end
		nb = 0;
		while (drv[0] === 1'b1 && nb < 2000) begin cyc(1); nb++; end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge hclk);
		n_errors++;
		$display("watchdog expired");
		summarize();
	end

	initial begin
		{hsel, hwrite, ot, uv, oc, chop, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		hresetn = 1'b0;
		cyc(2);
		`CHK({hiz, vreg, pos, f_oe, irq, hreadyout}, {1'b1, 1'b0, 7'h00, 1'b0, 1'b0, 1'b1})
		@(posedge hclk) hresetn <= 1'b1;
		ahb(1'b0, 32'h0000_0010, 32'h0);
		`CHK(rd, 32'h0)
		foreach (rows[i]) begin
			i_stfms_ctrl_model.steps(1, rows[i].d, rows[i].ms);
			`CHK(pos, rows[i].pos)
		end
		$display("step table done");
		i_stfms_ctrl_model.set_disable(1'b1);
		i_stfms_ctrl_model.steps(2, 1'b1, 3'h0);
		`CHK({pos, drv, dec}, {7'h20, 4'h0})
		i_stfms_ctrl_model.set_disable(1'b0);
		cyc(6);
		`CHK(pos, 7'h60)
		$display("disable done");
		@(posedge hclk) ot <= 1'b1;
		cyc(5);
		`CHK({drv, dec, f_oe, irq}, {4'h0, 1'b1, 1'b0})
		`CHK(f_o, 1'b0)
		ahb(1'b0, 32'h8, 32'h0);
		`CHK(rd[0], 1'b1)
		ahb(1'b1, 32'hc, 32'h1f);
		cyc(1);
		`CHK(irq, 1'b1)
		ahb(1'b1, 32'h8, 32'h1f);
		cyc(2);
		`CHK(irq, 1'b0)
		@(posedge hclk) ot <= 1'b0;
		for (int k = 0; k < 20 && drv[0] !== 1'b1; k++) cyc(1);
		`CHK({drv[0], f_oe}, 2'b11)
		cyc(3);
		`CHK(f_oe, 1'b0)
		$display("overtemp done");
		@(posedge hclk) oc <= 2'b01;
		cyc(30);
		@(posedge hclk) oc <= 2'b00;
		cyc(5);
		`CHK(f_oe, 1'b0)
		@(posedge hclk) oc <= 2'b01;
		cyc(60);
		`CHK({drv[0], dec[0], drv[1] | dec[1], f_oe}, 4'b0011)
		ahb(1'b0, 32'h4, 32'h0);
		`CHK(rd, 32'h0001_8121)
		@(posedge hclk) oc <= 2'b00;
		cyc(10);
		`CHK({drv[0], dec[0]}, 2'b00)
		cyc(40);
		`CHK(drv[0], 1'b1)
		cyc(3);
		`CHK({f_oe, irq}, 2'b01)
		ahb(1'b1, 32'h8, 32'h1f);
		$display("overcurrent done");
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, 32'h0, 32'(i * 5));
			@(posedge hclk) chop <= 2'b11;
			run_len();
			run_len();
			`CHK(nd >= off_c[i] - 1 && nd <= off_c[i] + 1, 1'b1)
			`CHK(nb >= blk_c[i] - 1 && nb <= blk_c[i] + 1, 1'b1)
			@(posedge hclk) chop <= 2'b00;
		end
		$display("chopper done");
		// Let the last decay run past its minimum before cutting the bridges
		cyc(10);
		@(posedge hclk) {uv, ot} <= 2'b11;
		cyc(5);
		`CHK({pos, hiz, vreg, f_oe}, {7'h00, 3'b101})
		@(posedge hclk) uv <= 1'b0;
		cyc(6);
		`CHK({hiz, vreg, f_oe}, 3'b011)
		@(posedge hclk) ot <= 1'b0;
		cyc(40);
		`CHK({hiz, f_oe}, 2'b00)
		$display("undervoltage done");
		ahb(1'b1, 32'hc, 32'h0);
		i_stfms_ctrl_model.go_sleep();
		cyc(10);
		`CHK(hiz, 1'b0)
		cyc(20);
		`CHK({hiz, vreg, drv}, 4'b1000)
		fork
			i_stfms_ctrl_model.wake();
			begin cyc(10); `CHK(hiz, 1'b1) end
		join
		cyc(2);
		`CHK({hiz, vreg}, 2'b01)
		$display("sleep done");
		summarize();
	end
endmodule
